/* rtl/vtc_transfer.sv */
// Value-transfer command interpreter: authenticate, then store tag value register
module vtc_transfer (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Host command
   input  wire logic                          cmd_start,
   input  wire logic [7:0]                    cmd_code,
   input  vtc_pkg::vtc_args_t                 cmd_args,
   output logic                               busy,
   // Host key store loading
   input  wire logic                          key_wr_en,
   input  wire logic [vtc_pkg::KEY_IDX_W-1:0] key_wr_idx,
   input  wire logic [vtc_pkg::KEY_W-1:0]     key_wr_data,
   // Result
   output logic                               res_valid,
   output vtc_pkg::vtc_res_t                  res_code,
   // Radio link engine
   output logic                               link_req,
   output vtc_pkg::vtc_link_t                 link_cmd,
   input  wire logic                          link_done,
   input  wire logic                          link_ok
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_KEY_RD,
      ST_AUTH,
      ST_XFER
   } vtc_state_t;

   vtc_state_t                  state;
   vtc_state_t                  next_state;
   logic [vtc_pkg::KEY_W-1:0]   key_rd_data;
   vtc_pkg::vtc_link_t          next_link_cmd;
   logic                        next_link_req;
   logic                        next_res_valid;
   vtc_pkg::vtc_res_t           next_res_code;

   // Decode of the incoming command
   wire logic       accept    = (state == ST_IDLE) && cmd_start;
   wire logic       is_xfer   = (cmd_code == vtc_pkg::CMD_TRANSFER);
   wire logic [5:0] key_idx   = cmd_args.key_num[vtc_pkg::KEY_IDX_W-1:0];
   wire logic       key_inarg = cmd_args.key_num[vtc_pkg::KEYNUM_ARG_BIT];
   wire logic       key_b     = cmd_args.key_num[vtc_pkg::KEYNUM_B_BIT];
   wire logic       idx_bad   = !key_inarg && (key_idx > vtc_pkg::KEY_IDX_MAX);
   wire logic       mem_rd    = accept && is_xfer && !key_inarg && !idx_bad;

   vtc_key_mem u_key_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .wr_en   (key_wr_en),
      .wr_idx  (key_wr_idx),
      .wr_data (key_wr_data),
      .rd_en   (mem_rd),
      .rd_idx  (key_idx),
      .rd_data (key_rd_data)
   );

   always_comb begin
      next_state     = state;
      next_link_cmd  = link_cmd;
      next_link_req  = 1'b0;
      next_res_valid = 1'b0;
      next_res_code  = res_code;
      unique case (state)
         ST_IDLE: begin
            if (accept) begin
               next_link_cmd.op    = vtc_pkg::VTC_OP_AUTH;
               next_link_cmd.block = cmd_args.block;
               next_link_cmd.key_b = key_b;
               next_link_cmd.key   = cmd_args.key;
               if (!is_xfer) begin
                  // Other codes belong to sibling interpreters; answer so host never hangs
                  next_res_valid = 1'b1;
                  next_res_code  = vtc_pkg::VTC_RES_BAD_CMD;
               end else if (idx_bad) begin
                  next_res_valid = 1'b1;
                  next_res_code  = vtc_pkg::VTC_RES_BAD_KEY;
               end else if (key_inarg) begin
                  next_link_req = 1'b1;
                  next_state    = ST_AUTH;
               end else begin
                  next_state = ST_KEY_RD;
               end
            end
         end
         ST_KEY_RD: begin
            next_link_cmd.key = key_rd_data;
            next_link_req     = 1'b1;
            next_state        = ST_AUTH;
         end
         ST_AUTH: begin
            if (link_done) begin
               if (link_ok) begin
                  // Tag transfer op copies value register and writes value format
                  next_link_cmd.op = vtc_pkg::VTC_OP_TRANSFER;
                  next_link_req    = 1'b1;
                  next_state       = ST_XFER;
               end else begin
                  next_res_valid = 1'b1;
                  next_res_code  = vtc_pkg::VTC_RES_AUTH_FAIL;
                  next_state     = ST_IDLE;
               end
            end
         end
         ST_XFER: begin
            if (link_done) begin
               next_res_valid = 1'b1;
               next_res_code  = link_ok ? vtc_pkg::VTC_RES_OK : vtc_pkg::VTC_RES_XFER_FAIL;
               next_state     = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state     <= ST_IDLE;
         link_cmd  <= '0;
         link_req  <= 1'b0;
         res_valid <= 1'b0;
         res_code  <= vtc_pkg::VTC_RES_OK;
         busy      <= 1'b0;
      end else begin
         state     <= next_state;
         link_cmd  <= next_link_cmd;
         link_req  <= next_link_req;
         res_valid <= next_res_valid;
         res_code  <= next_res_code;
         busy      <= (next_state != ST_IDLE);
      end
   end

   // Helper capture of the accepted arguments for checking
   vtc_pkg::vtc_args_t chk_args;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chk_args <= '0;
      end else if (accept) begin
         chk_args <= cmd_args;
      end
   end

   sequence s_accept_xfer;
      accept && is_xfer && !idx_bad;
   endsequence

   sequence s_auth_pass;
      state == ST_AUTH && link_done && link_ok;
   endsequence

   chk_cmd_decode: assert property (@(posedge clk) disable iff (!reset_n)
      accept && !is_xfer |=> res_valid && res_code == vtc_pkg::VTC_RES_BAD_CMD && !busy)
      else $error("foreign command code not refused");
   chk_block_dest: assert property (@(posedge clk) disable iff (!reset_n)
      link_req |-> link_cmd.block == chk_args.block)
      else $error("link block differs from argument");
   chk_key_range: assert property (@(posedge clk) disable iff (!reset_n)
      accept && is_xfer && idx_bad |=> res_valid && res_code == vtc_pkg::VTC_RES_BAD_KEY)
      else $error("out of range key index accepted");
   chk_key_select: assert property (@(posedge clk) disable iff (!reset_n)
      link_req |-> link_cmd.key_b == chk_args.key_num[vtc_pkg::KEYNUM_B_BIT])
      else $error("key A or B choice wrong");
   chk_arg_key: assert property (@(posedge clk) disable iff (!reset_n)
      s_accept_xfer ##0 key_inarg |=> link_req && link_cmd.key == chk_args.key)
      else $error("argument key not used");
   chk_stored_key: assert property (@(posedge clk) disable iff (!reset_n)
      s_accept_xfer ##0 !key_inarg |=> !link_req ##1 link_req && link_cmd.key == key_rd_data)
      else $error("stored key not used");
   chk_xfer_follow: assert property (@(posedge clk) disable iff (!reset_n)
      s_auth_pass |=> link_req && link_cmd.op == vtc_pkg::VTC_OP_TRANSFER)
      else $error("transfer not issued after authentication");
   chk_auth_fail: assert property (@(posedge clk) disable iff (!reset_n)
      state == ST_AUTH && link_done && !link_ok |=>
         res_valid && res_code == vtc_pkg::VTC_RES_AUTH_FAIL && !link_req)
      else $error("authentication failure not reported");
   chk_xfer_result: assert property (@(posedge clk) disable iff (!reset_n)
      state == ST_XFER && link_done |=> res_valid && !busy &&
         res_code == ($past(link_ok) ? vtc_pkg::VTC_RES_OK : vtc_pkg::VTC_RES_XFER_FAIL))
      else $error("transfer result wrong");

   sequence s_start_busy;
      cmd_start && busy;
   endsequence

   chk_busy_start: assert property (@(posedge clk) disable iff (!reset_n)
      s_accept_xfer |=> busy)
      else $error("accepted transfer did not raise busy");
   chk_bad_key_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      accept && is_xfer && idx_bad |=> !link_req && !busy)
      else $error("refused key index still reached the link");
   chk_res_idle: assert property (@(posedge clk) disable iff (!reset_n)
      res_valid |-> !busy)
      else $error("result shown while still busy");
   chk_req_busy: assert property (@(posedge clk) disable iff (!reset_n)
      link_req |-> busy)
      else $error("link request outside a command");
   chk_link_stable: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(link_cmd) && $past(busy) |-> link_req)
      else $error("link command changed without request");
   chk_xfer_order: assert property (@(posedge clk) disable iff (!reset_n)
      link_req && link_cmd.op == vtc_pkg::VTC_OP_TRANSFER |->
         $past(state == ST_AUTH && link_done && link_ok))
      else $error("transfer issued without passed authentication");
   chk_auth_first: assert property (@(posedge clk) disable iff (!reset_n)
      link_req && $past(state != ST_AUTH) |-> link_cmd.op == vtc_pkg::VTC_OP_AUTH)
      else $error("first link request not authentication");
   chk_start_ignored: assert property (@(posedge clk) disable iff (!reset_n)
      s_start_busy |=> $stable(link_cmd.block) && $stable(link_cmd.key_b))
      else $error("start while busy took new arguments");
   chk_reset_quiet: assert property (@(posedge clk)
      !reset_n |=> !busy && !res_valid && !link_req && res_code == vtc_pkg::VTC_RES_OK)
      else $error("outputs not quiet after reset");
endmodule

/* rtl/vtc_pkg.sv */
// Package for the value-transfer command interpreter
package vtc_pkg;
   localparam logic [7:0] CMD_TRANSFER   = 8'h0f;
   localparam int         ARG_BLOCK_OFS  = 'h00;
   localparam int         ARG_KEYNUM_OFS = 'h01;
   localparam int         ARG_KEY_OFS    = 'h02;
   localparam int         ARG_BYTES      = 8;
   localparam int         KEY_BYTES      = 6;
   localparam int         KEY_W          = 8 * KEY_BYTES;
   localparam int         KEY_COUNT      = 40;
   localparam int         KEY_IDX_W      = 6;
   localparam logic [5:0] KEY_IDX_MAX    = 6'h27;
   localparam int         KEYNUM_B_BIT   = 7;
   localparam int         KEYNUM_ARG_BIT = 6;

   // Argument bytes; block sits in byte 0, key LSB in byte 2
   typedef struct packed {
      logic [KEY_W-1:0] key;
      logic [7:0]       key_num;
      logic [7:0]       block;
   } vtc_args_t;

   typedef enum logic {
      VTC_OP_AUTH,
      VTC_OP_TRANSFER
   } vtc_op_t;

   typedef struct packed {
      vtc_op_t          op;
      logic [7:0]       block;
      logic [KEY_W-1:0] key;
      logic             key_b;
   } vtc_link_t;

   typedef enum logic [2:0] {
      VTC_RES_OK        = 3'h0,
      VTC_RES_BAD_CMD   = 3'h1,
      VTC_RES_BAD_KEY   = 3'h2,
      VTC_RES_AUTH_FAIL = 3'h3,
      VTC_RES_XFER_FAIL = 3'h4
   } vtc_res_t;
endpackage

/* rtl/vtc_key_mem.sv */
// Stored key set, one write port and one registered read port
module vtc_key_mem (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Write port
   input  wire logic                          wr_en,
   input  wire logic [vtc_pkg::KEY_IDX_W-1:0] wr_idx,
   input  wire logic [vtc_pkg::KEY_W-1:0]     wr_data,
   // Read port
   input  wire logic                          rd_en,
   input  wire logic [vtc_pkg::KEY_IDX_W-1:0] rd_idx,
   output logic      [vtc_pkg::KEY_W-1:0]     rd_data
);
   logic [vtc_pkg::KEY_W-1:0] mem [vtc_pkg::KEY_COUNT];

   // Array left without reset so it maps onto RAM
   always_ff @(posedge clk) begin
      if (wr_en && wr_idx <= vtc_pkg::KEY_IDX_MAX) begin
         mem[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else if (rd_en) begin
         rd_data <= mem[rd_idx];
      end
   end
endmodule

/* sim/vtc_tag_model.sv */
// Radio engine and tag model answering link requests
module vtc_tag_model (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Link from interpreter
   input  wire logic          link_req,
   input  vtc_pkg::vtc_link_t link_cmd,
   output logic               link_done,
   output logic               link_ok,
   // Scenario control and observation
   input  wire logic [3:0]    lat,
   input  wire logic          auth_ok,
   input  wire logic          xfer_ok,
   output vtc_pkg::vtc_link_t last_auth,
   output vtc_pkg::vtc_link_t last_xfer,
   output logic [7:0]         xfer_cnt
);
   vtc_pkg::vtc_link_t cur;
   logic [3:0]         cnt;
   logic               pend;
   wire                is_xfer = cur.op == vtc_pkg::VTC_OP_TRANSFER;

   always_ff @(posedge clk) begin
      link_done <= 1'b0;
      // Toggles outside done so a stray sample never looks stable
      link_ok <= ~link_ok;
      if (!reset_n) begin
         pend <= 1'b0;
         link_ok <= 1'b0;
         xfer_cnt <= 8'h00;
         last_auth <= '0;
         last_xfer <= '0;
      end else if (link_req) begin
         cur <= link_cmd;
         cnt <= lat;
         pend <= 1'b1;
      end else if (pend && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (pend) begin
         pend <= 1'b0;
         link_done <= 1'b1;
         link_ok <= is_xfer ? xfer_ok : auth_ok;
         if (is_xfer) last_xfer <= cur;
         else last_auth <= cur;
         // Value register taken as preloaded; copy into block as value format
         if (is_xfer && xfer_ok) xfer_cnt <= xfer_cnt + 8'h01;
      end
   end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the value-transfer interpreter
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset_n = 0, cmd_start = 0, key_wr_en = 0;
   logic [7:0] cmd_code = 8'h00;
   vtc_pkg::vtc_args_t cmd_args = '0;
   logic [5:0] key_wr_idx = 6'h00;
   logic [47:0] key_wr_data = 48'h0;
   logic busy, res_valid, link_req, link_done, link_ok, auth_ok = 1, xfer_ok = 1;
   logic [3:0] lat = 4'h0;
   logic [7:0] xfer_cnt, n0;
   vtc_pkg::vtc_res_t res_code, r;
   vtc_pkg::vtc_link_t link_cmd, last_auth, last_xfer;
   int fails = 0, check_count = 0, cyc = 0;

   always #12.5 clk = ~clk;

   vtc_transfer vtc_transfer_inst (.clk(clk), .reset_n(reset_n), .cmd_start(cmd_start),
      .cmd_code(cmd_code), .cmd_args(cmd_args), .busy(busy), .key_wr_en(key_wr_en),
      .key_wr_idx(key_wr_idx), .key_wr_data(key_wr_data), .res_valid(res_valid),
      .res_code(res_code), .link_req(link_req), .link_cmd(link_cmd),
      .link_done(link_done), .link_ok(link_ok));
   vtc_tag_model vtc_tag_model_inst (.clk(clk), .reset_n(reset_n), .link_req(link_req),
      .link_cmd(link_cmd), .link_done(link_done), .link_ok(link_ok), .lat(lat),
      .auth_ok(auth_ok), .xfer_ok(xfer_ok), .last_auth(last_auth), .last_xfer(last_xfer),
      .xfer_cnt(xfer_cnt));

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic cmp_val(input logic [63:0] g, input logic [63:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // Result pulse may already stand in the cycle right after the accepting edge
   task automatic wait_res();
      int n;
      n = 0;
      #1;
      while (res_valid !== 1'b1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp_val(64'(res_valid), 64'h1);
      cmp_val(64'(busy), 64'h0);
      r = res_code;
      @(posedge clk);
      #1;
      cmp_val(64'(res_valid), 64'h0);
   endtask

   task automatic run(input logic [7:0] code, input logic [7:0] blk, input logic [7:0] kn,
                      input logic [47:0] key);
      n0 = xfer_cnt;
      @(posedge clk);
      cmd_start <= 1'b1;
      cmd_code <= code;
      cmd_args <= '{key: key, key_num: kn, block: blk};
      @(posedge clk);
      cmd_start <= 1'b0;
      wait_res();
   endtask

   task automatic t_busy();
      // Second start while busy carries other arguments and must be ignored
      @(posedge clk);
      cmd_start <= 1'b1;
      cmd_code <= 8'h0f;
      cmd_args <= '{key: 48'h0a0b0c0d0e0f, key_num: 8'h40, block: 8'h21};
      @(posedge clk);
      cmd_args <= '{key: 48'h0, key_num: 8'hc0, block: 8'h77};
      @(posedge clk);
      cmd_start <= 1'b0;
      wait_res();
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_OK));
      cmp_val(64'(last_auth), lk(1'b0, 8'h21, 48'h0a0b0c0d0e0f, 1'b0));
      cmp_val(64'(last_xfer), lk(1'b1, 8'h21, 48'h0a0b0c0d0e0f, 1'b0));
      $display("busy start test done");
   endtask

   function automatic logic [63:0] lk(input logic op, input logic [7:0] b,
                                      input logic [47:0] k, input logic kb);
      return 64'({op, b, k, kb});
   endfunction

   task automatic t_explicit();
      // Key bytes 0x11..0x66 sent low byte first
      run(8'h0f, 8'h09, 8'hc0, 48'h665544332211);
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_OK));
      cmp_val(64'(last_auth), lk(1'b0, 8'h09, 48'h665544332211, 1'b1));
      cmp_val(64'(last_xfer), lk(1'b1, 8'h09, 48'h665544332211, 1'b1));
      cmp_val(64'(xfer_cnt), 64'(n0 + 8'h01));
      $display("explicit key test done");
   endtask

   task automatic t_stored();
      @(posedge clk);
      key_wr_en <= 1'b1;
      key_wr_idx <= 6'h27;
      key_wr_data <= 48'ha1b2c3d4e5f6;
      @(posedge clk);
      key_wr_en <= 1'b0;
      lat <= 4'h9;
      // Argument key must be ignored with stored selection
      run(8'h0f, 8'h3c, 8'h27, 48'hffffffffffff);
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_OK));
      cmp_val(64'(last_auth), lk(1'b0, 8'h3c, 48'ha1b2c3d4e5f6, 1'b0));
      cmp_val(64'(last_xfer), lk(1'b1, 8'h3c, 48'ha1b2c3d4e5f6, 1'b0));
      lat <= 4'h0;
      $display("stored key test done");
   endtask

   task automatic t_refused();
      logic [7:0] codes [3] = '{8'h0e, 8'h10, 8'h00};
      run(8'h0f, 8'h05, 8'h28, 48'h0);
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_BAD_KEY));
      foreach (codes[i]) begin
         run(codes[i], 8'h05, 8'hc0, 48'h1);
         cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_BAD_CMD));
      end
      cmp_val(64'(last_auth[56:49]), 64'h3c);
      $display("refusal test done");
   endtask

   task automatic t_fail();
      auth_ok <= 1'b0;
      run(8'h0f, 8'h11, 8'h40, 48'h123456789abc);
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_AUTH_FAIL));
      cmp_val(64'(xfer_cnt), 64'(n0));
      auth_ok <= 1'b1;
      xfer_ok <= 1'b0;
      run(8'h0f, 8'h12, 8'h40, 48'h123456789abc);
      cmp_val(64'(r), 64'(vtc_pkg::VTC_RES_XFER_FAIL));
      cmp_val(64'(last_xfer), lk(1'b1, 8'h12, 48'h123456789abc, 1'b0));
      xfer_ok <= 1'b1;
      $display("failure test done");
   endtask

   // Five tests take well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_explicit();
      t_stored();
      t_refused();
      t_fail();
      t_busy();
      test_done();
   end
endmodule
